// ==== mpcr_pkg.sv ====
package mpcr_pkg;
  // Register word offsets.
  localparam logic [7:0] MPCR_PERI_ADDR = 8'hAA;
  localparam logic [7:0] MPCR_GATE_ADDR = 8'hAC;
  // Reset values.
  localparam logic [31:0] MPCR_PERI_RESET = 32'h40000000;
  localparam logic [31:0] MPCR_GATE_RESET = 32'h10228100;
  // Peripheral word field positions.
  localparam int MPCR_DITHER_OFF_BIT = 30;
  localparam int MPCR_CAP_HI = 25;
  localparam int MPCR_CAP_LO = 22;
  localparam int MPCR_CAP_EN_BIT = 21;
  localparam int MPCR_ROT_HI = 20;
  localparam int MPCR_ROT_LO = 19;
  localparam int MPCR_REV_POLICY_BIT = 18;
  localparam int MPCR_SELF_TEST_BIT = 17;
  localparam int MPCR_GAP_HI = 16;
  localparam int MPCR_GAP_LO = 13;
  localparam int MPCR_MOD_HI = 12;
  localparam int MPCR_MOD_LO = 10;
  localparam int MPCR_RANGE_BIT = 9;
  localparam int MPCR_ALERT_OFF_BIT = 8;
  // Gate-driver word field positions.
  localparam int MPCR_EDGE_HI = 27;
  localparam int MPCR_EDGE_LO = 26;
  localparam int MPCR_OV_LEVEL_BIT = 19;
  localparam int MPCR_OV_GUARD_BIT = 18;
  localparam int MPCR_HEAT_REP_BIT = 16;
  localparam int MPCR_FILT_HI = 13;
  localparam int MPCR_FILT_LO = 12;
  localparam int MPCR_RETRY_BIT = 11;
  localparam int MPCR_OC_THR_BIT = 10;
  localparam int MPCR_OC_RESP_HI = 9;
  localparam int MPCR_OC_RESP_LO = 8;
  localparam int MPCR_GAIN_HI = 1;
  localparam int MPCR_GAIN_LO = 0;
  // Rotation override codes.
  localparam logic [1:0] MPCR_ROT_FWD = 2'h1;
  localparam logic [1:0] MPCR_ROT_REV = 2'h2;
  // Overcurrent response encoding.
  typedef enum logic [1:0] {
    MPCR_OC_LATCH = 2'b00,
    MPCR_OC_RETRY = 2'b01,
    MPCR_OC_REPORT = 2'b10,
    MPCR_OC_IGNORE = 2'b11
  } mpcr_oc_e;
  // Undocumented brake gap code.
  localparam logic [3:0] MPCR_GAP_RSVD = 4'hE;
  // Supply cap in milliamps, brake gap in tenths of a percent.
  localparam int MPCR_CAP_W = 14;
  localparam int MPCR_PCT_W = 10;
endpackage : mpcr_pkg

// ==== mpcr_cfg_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Register write strobe and both stored words shared inside the bank.
interface mpcr_cfg_if;
  logic wr_en;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] peri;
  logic [31:0] gate;
  modport store (input wr_en, input addr, input wdata, output peri, output gate);
  modport user (output wr_en, output addr, output wdata, input peri, input gate);
endinterface : mpcr_cfg_if
`default_nettype wire

// ==== mpcr_store.sv ====
`timescale 1ns/1ps
`default_nettype none
module mpcr_store
  import mpcr_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic srst_in,
  mpcr_cfg_if.store cfg
);
  typedef struct packed {
    logic [31:0] peri;
    logic [31:0] gate;
  } mpcr_store_s;
  mpcr_store_s st_q;
  mpcr_store_s st_d;

  // Whole-word writes; every bit, check and reserved ones too, reads back as written.
  always_comb begin
    st_d = st_q;
    if (cfg.wr_en && cfg.addr == MPCR_PERI_ADDR) begin
      st_d.peri = cfg.wdata;
    end
    if (cfg.wr_en && cfg.addr == MPCR_GATE_ADDR) begin
      st_d.gate = cfg.wdata;
    end
  end

  // Reset loads documented defaults.
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      st_q <= '{peri: MPCR_PERI_RESET, gate: MPCR_GATE_RESET};
    end else begin
      st_q <= st_d;
    end
  end

  assign cfg.peri = st_q.peri;
  assign cfg.gate = st_q.gate;
endmodule : mpcr_store
`default_nettype wire

// ==== mpcr_regs.sv ====
// Contract
// - Bit 30 set turns clock dithering off
// - Bits 25-22 select supply draw cap
// - Cap applied only when bit 21 set
// - Bits 20-19 override rotation direction
// - Bit 18 picks reversal policy on change
// - Bit 17 enables power-up self-test
// - Bits 16-13 set brake speed gap
// - Bits 12-10 set brake modulation limit
// - Range bit selects speed input band
// - Bit 8 set disables alert output
// - Gate word at ACh, reset 10228100h
// - Gate word field layout fixed
// - Bits 9-8 choose overcurrent response
// - Fixed gain used only without autogain
// - Peripheral word at AAh, reset 40000000h
`timescale 1ns/1ps
`default_nettype none
module mpcr_regs
  import mpcr_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic dir_pin_in,
  input wire logic auto_sense_gain_on_in,
  output logic [31:0] rdata_out,
  output logic rvalid_out,
  output logic clock_dithering_out,
  output logic [MPCR_CAP_W-1:0] cap_ma_out,
  output logic cap_active_out,
  output logic rot_acb_out,
  output logic dir_change_out,
  output logic rev_drive_out,
  output logic stop_then_detect_out,
  output logic power_up_check_out,
  output logic [MPCR_PCT_W-1:0] gap_tenth_pct_out,
  output logic gap_reserved_out,
  output logic [6:0] mod_pct_out,
  output logic low_speed_band_out,
  output logic alert_output_on_out,
  output logic [1:0] edge_speed_out,
  output logic overvoltage_level_out,
  output logic overvoltage_guard_on_out,
  output logic heat_warning_report_out,
  output logic [1:0] overcurrent_filter_time_out,
  output logic overcurrent_retry_time_out,
  output logic overcurrent_threshold_out,
  output logic oc_latch_out,
  output logic oc_retry_out,
  output logic oc_report_out,
  output logic sense_gain_fixed_out,
  output logic [1:0] sense_amp_gain_out
);
  mpcr_cfg_if cfg();

  assign cfg.wr_en = wr_en_in;
  assign cfg.addr = addr_in;
  assign cfg.wdata = wdata_in;

  mpcr_store mpcr_store_inst (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .cfg(cfg.store)
  );

  // Supply cap step table in milliamps.
  function automatic logic [MPCR_CAP_W-1:0] cap_ma(input logic [3:0] code);
    case (code)
      4'h0: cap_ma = 14'd125;
      4'h1: cap_ma = 14'd250;
      4'h2: cap_ma = 14'd500;
      4'hE: cap_ma = 14'd7000;
      4'hF: cap_ma = 14'd8000;
      default: cap_ma = 14'(({10'h0, code} - 14'd1) * 14'd500);
    endcase
  endfunction : cap_ma

  // Brake gap table in tenths of a percent; E is unassigned and yields zero.
  function automatic logic [MPCR_PCT_W-1:0] gap_tenth(input logic [3:0] code);
    case (code)
      4'h0: gap_tenth = 10'd25;
      4'hB: gap_tenth = 10'd600;
      4'hC: gap_tenth = 10'd700;
      4'hD: gap_tenth = 10'd800;
      4'hE: gap_tenth = 10'd0;
      4'hF: gap_tenth = 10'd1000;
      default: gap_tenth = 10'({6'h0, code} * 10'd50);
    endcase
  endfunction : gap_tenth

  typedef struct packed {
    logic [31:0] rdata;
    logic rvalid;
    logic dir_eff;
  } mpcr_regs_s;
  mpcr_regs_s st_q;
  mpcr_regs_s st_d;

  logic [1:0] rot_code;
  logic dir_eff;
  logic [2:0] mod_code;
  logic [1:0] oc_code;

  assign rot_code = cfg.peri[MPCR_ROT_HI:MPCR_ROT_LO];
  assign dir_eff = (rot_code == MPCR_ROT_FWD) ? 1'b0 :
                   (rot_code == MPCR_ROT_REV) ? 1'b1 : dir_pin_in;
  assign rot_acb_out = dir_eff;

  // Read mux and direction tracking; unmapped reads return zero.
  always_comb begin
    st_d = st_q;
    st_d.rvalid = rd_en_in;
    st_d.dir_eff = dir_eff;
    if (rd_en_in) begin
      case (addr_in)
        MPCR_PERI_ADDR: st_d.rdata = cfg.peri;
        MPCR_GATE_ADDR: st_d.rdata = cfg.gate;
        default: st_d.rdata = 32'h00000000;
      endcase
    end
  end

  // Direction history seeds from the pin, as the reset word leaves the override off.
  // A constant seed would report a reversal after every reset taken with the pin high.
  // no false change
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      st_q <= '{rdata: 32'h00000000, rvalid: 1'b0, dir_eff: dir_pin_in};
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata_out = st_q.rdata;
  assign rvalid_out = st_q.rvalid;

  assign dir_change_out = dir_eff ^ st_q.dir_eff;
  assign rev_drive_out = dir_change_out && cfg.peri[MPCR_REV_POLICY_BIT];
  assign stop_then_detect_out = dir_change_out && !cfg.peri[MPCR_REV_POLICY_BIT];

  assign clock_dithering_out = !cfg.peri[MPCR_DITHER_OFF_BIT];
  assign cap_ma_out = cap_ma(cfg.peri[MPCR_CAP_HI:MPCR_CAP_LO]);
  assign cap_active_out = cfg.peri[MPCR_CAP_EN_BIT];
  assign power_up_check_out = cfg.peri[MPCR_SELF_TEST_BIT];
  assign gap_tenth_pct_out = gap_tenth(cfg.peri[MPCR_GAP_HI:MPCR_GAP_LO]);
  assign gap_reserved_out = cfg.peri[MPCR_GAP_HI:MPCR_GAP_LO] == MPCR_GAP_RSVD;
  assign mod_code = cfg.peri[MPCR_MOD_HI:MPCR_MOD_LO];
  assign mod_pct_out = (mod_code == 3'h0) ? 7'd0 : 7'(7'd30 + {4'h0, mod_code} * 7'd10);
  assign low_speed_band_out = cfg.peri[MPCR_RANGE_BIT];
  assign alert_output_on_out = !cfg.peri[MPCR_ALERT_OFF_BIT];

  assign edge_speed_out = cfg.gate[MPCR_EDGE_HI:MPCR_EDGE_LO];
  assign overvoltage_level_out = cfg.gate[MPCR_OV_LEVEL_BIT];
  assign overvoltage_guard_on_out = cfg.gate[MPCR_OV_GUARD_BIT];
  assign heat_warning_report_out = cfg.gate[MPCR_HEAT_REP_BIT];
  assign overcurrent_filter_time_out = cfg.gate[MPCR_FILT_HI:MPCR_FILT_LO];
  assign overcurrent_retry_time_out = cfg.gate[MPCR_RETRY_BIT];
  assign overcurrent_threshold_out = cfg.gate[MPCR_OC_THR_BIT];

  assign oc_code = cfg.gate[MPCR_OC_RESP_HI:MPCR_OC_RESP_LO];
  assign oc_latch_out = oc_code == MPCR_OC_LATCH;
  assign oc_retry_out = oc_code == MPCR_OC_RETRY;
  assign oc_report_out = oc_code != MPCR_OC_IGNORE;

  assign sense_gain_fixed_out = !auto_sense_gain_on_in;
  assign sense_amp_gain_out = cfg.gate[MPCR_GAIN_HI:MPCR_GAIN_LO];

  // Write followed by read-back shows the written word.
  sequence s_peri_wr;
    wr_en_in && addr_in == MPCR_PERI_ADDR && !srst_in;
  endsequence
  property p_readback;
    @(posedge sys_clk_in) disable iff (srst_in)
    s_peri_wr ##1 (rd_en_in && addr_in == MPCR_PERI_ADDR && !wr_en_in)
      |=> rdata_out == $past(wdata_in, 2);
  endproperty
  a_readback: assert property (p_readback) else $error("readback mismatch");
  property p_reset_peri;
    @(posedge sys_clk_in) srst_in |=> cfg.peri == MPCR_PERI_RESET;
  endproperty
  a_reset_peri: assert property (p_reset_peri) else $error("peri reset bad");
  property p_reset_gate;
    @(posedge sys_clk_in) srst_in |=> cfg.gate == MPCR_GATE_RESET && oc_retry_out;
  endproperty
  a_reset_gate: assert property (p_reset_gate) else $error("gate reset bad");
  property p_dither;
    @(posedge sys_clk_in) srst_in |=> !clock_dithering_out && !cap_active_out;
  endproperty
  a_dither: assert property (p_dither) else $error("dither default bad");
  property p_cap;
    @(posedge sys_clk_in) disable iff (srst_in)
    cfg.peri[MPCR_CAP_HI:MPCR_CAP_LO] == 4'hF |-> cap_ma_out == 14'd8000;
  endproperty
  a_cap: assert property (p_cap) else $error("cap decode bad");
  property p_rot;
    @(posedge sys_clk_in) disable iff (srst_in)
    rot_code == MPCR_ROT_REV |-> rot_acb_out;
  endproperty
  a_rot: assert property (p_rot) else $error("rotation override bad");
  property p_rev;
    @(posedge sys_clk_in) disable iff (srst_in)
    ($changed(dir_eff) && cfg.peri[MPCR_REV_POLICY_BIT]) |-> rev_drive_out;
  endproperty
  a_rev: assert property (p_rev) else $error("reversal policy bad");
  // A steady pin across reset must not look like a direction change.
  property p_reset_dir;
    @(posedge sys_clk_in) srst_in ##1 $stable(dir_pin_in) |-> !dir_change_out;
  endproperty
  a_reset_dir: assert property (p_reset_dir) else $error("false direction change");
  property p_gap;
    @(posedge sys_clk_in) disable iff (srst_in)
    cfg.peri[MPCR_GAP_HI:MPCR_GAP_LO] == 4'hA |-> gap_tenth_pct_out == 10'd500;
  endproperty
  a_gap: assert property (p_gap) else $error("gap decode bad");
  property p_mod;
    @(posedge sys_clk_in) disable iff (srst_in)
    mod_code == 3'h7 |-> mod_pct_out == 7'd100;
  endproperty
  a_mod: assert property (p_mod) else $error("mod decode bad");
  property p_alert;
    @(posedge sys_clk_in) disable iff (srst_in)
    alert_output_on_out != cfg.peri[MPCR_ALERT_OFF_BIT];
  endproperty
  a_alert: assert property (p_alert) else $error("alert gate bad");
endmodule : mpcr_regs
`default_nettype wire

// ==== mpcr_regs_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module mpcr_regs_test
  import mpcr_pkg::*;
();
  logic sys_clk, srst, wr_en, rd_en, dir_pin, again, rvalid, dith, cap_act, rot, dchg;
  logic rev, stopd, puchk, gap_rsvd, lband, alert, ovl, ovg, heat, rtry, thr;
  logic latch, retry, rept, gfix;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [MPCR_CAP_W-1:0] cap;
  logic [MPCR_PCT_W-1:0] gap;
  logic [6:0] modp;
  logic [1:0] edg, filt, gain;
  int fail_count, checks_done;
  mpcr_regs mpcr_regs_inst (.sys_clk_in(sys_clk), .srst_in(srst), .wr_en_in(wr_en),
    .rd_en_in(rd_en), .addr_in(addr), .wdata_in(wdata), .dir_pin_in(dir_pin),
    .auto_sense_gain_on_in(again), .rdata_out(rdata), .rvalid_out(rvalid),
    .clock_dithering_out(dith), .cap_ma_out(cap), .cap_active_out(cap_act),
    .rot_acb_out(rot), .dir_change_out(dchg), .rev_drive_out(rev),
    .stop_then_detect_out(stopd), .power_up_check_out(puchk), .gap_tenth_pct_out(gap),
    .gap_reserved_out(gap_rsvd), .mod_pct_out(modp), .low_speed_band_out(lband),
    .alert_output_on_out(alert), .edge_speed_out(edg), .overvoltage_level_out(ovl),
    .overvoltage_guard_on_out(ovg), .heat_warning_report_out(heat),
    .overcurrent_filter_time_out(filt), .overcurrent_retry_time_out(rtry),
    .overcurrent_threshold_out(thr), .oc_latch_out(latch), .oc_retry_out(retry),
    .oc_report_out(rept), .sense_gain_fixed_out(gfix), .sense_amp_gain_out(gain));
  // The clock toggles every half period of 12.5 ns.
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask : chk_bit
  // Writes hold for one edge; the idle edge after keeps strobes from merging.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    @(negedge sys_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    @(negedge sys_clk);
    chk_bit(rvalid, 1'b1);
    chk_word(rdata, exp);
  endtask : rd
  // Reset must not leave a phantom direction change behind it.
  task automatic t_reset();
    @(negedge sys_clk);
    chk_bit(dchg, 1'b0);
    chk_bit(lband, 1'b0);
    rd(MPCR_PERI_ADDR, 32'h40000000);
    rd(MPCR_GATE_ADDR, 32'h10228100);
    chk_bit(dith, 1'b0);
    chk_bit(cap_act, 1'b0);
    chk_bit(puchk, 1'b0);
    chk_bit(alert, 1'b1);
    chk_bit(retry, 1'b1);
  endtask : t_reset
  // An unmapped write must leave the peripheral word alone, and an unmapped read returns zero.
  task automatic t_unmapped();
    wr(8'hAB, 32'hFFFFFFFF);
    rd(8'hAB, 32'h00000000);
    rd(MPCR_PERI_ADDR, 32'h40000000);
  endtask : t_unmapped
  task automatic t_cap();
    int e;
    for (int c = 0; c < 16; c++) begin
      wr(MPCR_PERI_ADDR, (c << 22) | (32'h1 << 21));
      e = (c < 3) ? (125 << c) : (c < 14) ? 1000 + (c - 3) * 500 : 7000 + (c - 14) * 1000;
      chk_word(32'(cap), e);
      chk_bit(cap_act, 1'b1);
      chk_bit(dith, 1'b1);
    end
  endtask : t_cap
  task automatic t_brake();
    int g;
    for (int c = 0; c < 16; c++) begin
      wr(MPCR_PERI_ADDR, (c << 13) | ((c & 7) << 10));
      g = (c == 0) ? 25 : (c < 11) ? c * 50 : (c < 14) ? 500 + (c - 10) * 100 : (c - 14) * 1000;
      chk_word(32'(gap), g);
      chk_bit(gap_rsvd, c == 14);
      chk_word(32'(modp), ((c & 7) == 0) ? 0 : 30 + (c & 7) * 10);
    end
  endtask : t_brake
  // Every override code against both pin levels.
  task automatic t_rot();
    for (int c = 0; c < 8; c++) begin
      @(posedge sys_clk);
      dir_pin <= c[2];
      wr(MPCR_PERI_ADDR, (c & 3) << 19);
      chk_bit(rot, ((c & 3) == 1) ? 1'b0 : ((c & 3) == 2) ? 1'b1 : c[2]);
    end
  endtask : t_rot
  task automatic t_rev();
    for (int p = 0; p < 2; p++) begin
      wr(MPCR_PERI_ADDR, p << 18);
      @(posedge sys_clk);
      dir_pin <= ~dir_pin;
      @(negedge sys_clk);
      chk_bit(rev, p[0]);
      chk_bit(stopd, !p[0]);
      @(negedge sys_clk);
      chk_bit(dchg, 1'b0);
    end
  endtask : t_rev
  // Check and reserved bits must read back exactly.
  task automatic t_misc();
    wr(MPCR_PERI_ADDR, 32'hBC0203A5);
    rd(MPCR_PERI_ADDR, 32'hBC0203A5);
    chk_bit(puchk, 1'b1);
    chk_bit(lband, 1'b1);
    chk_bit(alert, 1'b0);
  endtask : t_misc
  // A read right behind a write must already see the new word.
  task automatic t_b2b();
    @(posedge sys_clk);
    wr_en <= 1'b1;
    addr <= MPCR_PERI_ADDR;
    wdata <= 32'h12345678;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    @(negedge sys_clk);
    chk_bit(rvalid, 1'b1);
    chk_word(rdata, 32'h12345678);
  endtask : t_b2b
  task automatic t_gate();
    logic [1:0] k;
    logic [31:0] w;
    for (int i = 0; i < 4; i++) begin
      k = i[1:0];
      w = ({30'h0, k} << 26) | ({31'h0, k[1]} << 19) | ({31'h0, k[0]} << 18);
      w = w | ({31'h0, k[0]} << 16) | ({30'h0, k} << 12) | ({31'h0, k[1]} << 11);
      w = w | ({31'h0, k[0]} << 10) | ({30'h0, k} << 8) | {30'h0, k} | 32'hE0000000;
      @(posedge sys_clk);
      again <= k[0];
      wr(MPCR_GATE_ADDR, w);
      rd(MPCR_GATE_ADDR, w);
      chk_word(32'({edg, ovl, ovg, heat, filt, rtry, thr, gain}),
        32'({k, k, k[0], k, k, k}));
      chk_word(32'({latch, retry, rept}), 32'({k == 2'h0, k == 2'h1, k != 2'h3}));
      chk_bit(gfix, !k[0]);
    end
  endtask : t_gate
  task automatic report_and_stop();
    if (fail_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop
  // The whole sequence needs well under a thousand cycles.
  initial begin
    #100000;
    fail_count++;
    report_and_stop();
  end
  // Reset, scenarios, then a reset in mid-run.
  initial begin
    {srst, wr_en, rd_en, dir_pin, again, addr, wdata} = {1'b1, 44'h0};
    fail_count = 0;
    checks_done = 0;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset();
    t_unmapped();
    t_cap();
    t_brake();
    t_rot();
    t_rev();
    t_misc();
    t_b2b();
    t_gate();
    @(posedge sys_clk);
    srst <= 1'b1;
    @(posedge sys_clk);
    srst <= 1'b0;
    t_reset();
    report_and_stop();
  end
endmodule : mpcr_regs_test
`default_nettype wire
